// >>> rsl_pkg.sv
`default_nettype none
package rsl_pkg;
	typedef logic [3:0] rsl_reg_addr_t;
	typedef logic [7:0] rsl_byte_t;
	typedef logic [9:0] rsl_dev_addr_t;
	typedef enum logic [1:0] {RSL_LK_FREE = 2'h0, RSL_LK_OFF = 2'h1, RSL_LK_HOLD = 2'h2, RSL_LK_ON = 2'h3} rsl_lock_t;
	typedef enum logic [1:0] {RSL_SEQ_IDLE = 2'h0, RSL_SEQ_ISSUE = 2'h1, RSL_SEQ_WAIT = 2'h2} rsl_seq_t;
	typedef enum logic [1:0] {RSL_SETUP_PRE = 2'h1, RSL_SETUP_SYNC = 2'h2, RSL_SETUP_NOAFC = 2'h3} rsl_setup_t;
	// device locations
	localparam rsl_dev_addr_t RSL_MCR_LOWER = 10'h35e;
	localparam rsl_dev_addr_t RSL_MCR_UPPER = 10'h35f;
	localparam rsl_dev_addr_t RSL_MCR_DIV = 10'h32f;
	localparam rsl_dev_addr_t RSL_AFC_MODE = 10'h116;
	localparam rsl_dev_addr_t RSL_AFC_GAIN = 10'h117;
	localparam rsl_dev_addr_t RSL_PRE_MATCH = 10'h11b;
	localparam rsl_dev_addr_t RSL_PRE_LEN = 10'h11d;
	localparam rsl_dev_addr_t RSL_SYNC_CFG = 10'h120;
	localparam rsl_dev_addr_t RSL_FIX_PTR = 10'h128;
	localparam logic [1:0] RSL_RET_PAGE_HI = 2'h1;
	// recommended values
	localparam rsl_byte_t RSL_UPPER_REC = 8'h78;
	localparam rsl_byte_t RSL_LOWER_REC = 8'h46;
	localparam rsl_byte_t RSL_DIV_FAST = 8'h0f;
	localparam rsl_byte_t RSL_DIV_STD = 8'h19;
	localparam logic [3:0] RSL_KI_STD = 4'h7;
	localparam logic [3:0] RSL_KI_FAST = 4'h8;
	localparam logic [3:0] RSL_KP_STD = 4'h3;
	localparam rsl_byte_t RSL_LIST_END = 8'h00;
	localparam rsl_byte_t RSL_BASE_RST = 8'h2b;
	localparam rsl_byte_t RSL_PRE_RST = 8'h08;
	// field positions inside device bytes
	localparam int RSL_AFC_LSB = 0;
	localparam int RSL_AGC_LSB = 2;
	// minimum preamble bits per setup
	localparam logic [6:0] RSL_MIN_PRE = 7'h28;
	localparam logic [6:0] RSL_MIN_SYNC = 7'h0e;
	localparam logic [6:0] RSL_MIN_NOAFC = 7'h08;
	// own register offsets
	localparam rsl_reg_addr_t RSL_REG_CTRL = 4'h0;
	localparam rsl_reg_addr_t RSL_REG_SETUP = 4'h1;
	localparam rsl_reg_addr_t RSL_REG_PRE = 4'h2;
	localparam rsl_reg_addr_t RSL_REG_BASE = 4'h3;
	localparam rsl_reg_addr_t RSL_REG_UPPER = 4'h4;
	localparam rsl_reg_addr_t RSL_REG_LOWER = 4'h5;
	localparam rsl_reg_addr_t RSL_REG_STATUS = 4'h6;
	// sequence steps
	localparam logic [3:0] RSL_STEP_MCR_LAST = 4'h2;
	localparam logic [3:0] RSL_STEP_LIST0 = 4'h9;
	localparam logic [3:0] RSL_STEP_LAST = 4'hf;
endpackage
`default_nettype wire

// >>> rsl_wr_if.sv
`default_nettype none
interface rsl_wr_if;
	logic req;
	logic [9:0] addr;
	logic [7:0] data;
	logic done;
	modport src(output req, output addr, output data, input done);
	modport snk(input req, input addr, input data, output done);
endinterface
`default_nettype wire

// >>> rsl_cfg_enc.sv
`default_nettype none
module rsl_cfg_enc #(
	parameter logic [7:0] PRE_MATCH_ON = 8'h01,
	parameter logic [7:0] AFC_MODE_BASE = 8'h00,
	parameter logic [7:0] SYNC_CFG_BASE = 8'h00
) (
	input wire logic [1:0] setup,
	input wire logic rate300,
	input wire logic rate_fast,
	output logic [7:0] div,
	output logic [7:0] mode,
	output logic [7:0] gain,
	output logic [7:0] prematch,
	output logic [7:0] sync,
	output logic [6:0] min_bits
);
	import rsl_pkg::*;
	logic s2;
	logic s3;
	logic s1;
	rsl_lock_t afc_sel;
	always_comb begin
		s2 = (setup == RSL_SETUP_SYNC);
		s3 = (setup == RSL_SETUP_NOAFC);
		s1 = !s2 && !s3;
		div = (rate300 && s1) ? RSL_DIV_FAST : RSL_DIV_STD;
		afc_sel = s3 ? RSL_LK_OFF : RSL_LK_ON;
		mode = AFC_MODE_BASE | (8'({6'h00, afc_sel}) << RSL_AFC_LSB) | (8'({6'h00, RSL_LK_ON}) << RSL_AGC_LSB);
		gain = {(rate300 && s2) ? RSL_KI_FAST : RSL_KI_STD, RSL_KP_STD};
		prematch = s1 ? PRE_MATCH_ON : 8'h00;
		sync = SYNC_CFG_BASE | {7'h00, rate_fast && !s1};
		// sync-lock minimums hold for a 24-bit sync word only
		min_bits = s1 ? RSL_MIN_PRE : (s2 ? RSL_MIN_SYNC : RSL_MIN_NOAFC);
	end
endmodule
`default_nettype wire

// >>> rsl_spi_wr.sv
`default_nettype none
module rsl_spi_wr #(
	parameter int HALF = 2,
	parameter logic [7:0] WR_CMD = 8'h01 // arbitrary command code
) (
	input wire logic clock,
	input wire logic rst,
	rsl_wr_if.snk wr,
	output logic sclk,
	output logic mosi,
	output logic cs_n
);
	import rsl_pkg::*;
	typedef struct packed {
		logic active;
		logic [31:0] sh;
		logic [4:0] bits;
		logic [7:0] cnt;
		logic sclk;
		logic mosi;
		logic cs_n;
		logic done;
	} rsl_spi_st_t;
	localparam rsl_spi_st_t ST_RST = '{active: 1'b0, sh: 32'h0, bits: 5'h0, cnt: 8'h0, sclk: 1'b0,
		mosi: 1'b0, cs_n: 1'b1, done: 1'b0};
	rsl_spi_st_t q;
	rsl_spi_st_t d;
	always_comb begin
		d = q;
		d.done = 1'b0;
		if (!q.active) begin
			if (wr.req) begin
				d.active = 1'b1;
				d.cs_n = 1'b0;
				d.sh = {WR_CMD, 6'h00, wr.addr, wr.data};
				d.mosi = WR_CMD[7];
				d.bits = 5'h0;
				d.cnt = 8'h0;
			end
		end else if (q.cnt == 8'(HALF - 1)) begin
			d.cnt = 8'h0;
			d.sclk = !q.sclk;
			// data changes on the falling edge, device samples on rising
			if (q.sclk) begin
				if (q.bits == 5'h1f) begin
					d.active = 1'b0;
					d.cs_n = 1'b1;
					d.done = 1'b1;
				end else begin
					d.sh = q.sh << 1;
					d.mosi = q.sh[30];
					d.bits = q.bits + 5'h1;
				end
			end
		end else begin
			d.cnt = q.cnt + 8'h1;
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end
	assign wr.done = q.done;
	assign sclk = q.sclk;
	assign mosi = q.mosi;
	assign cs_n = q.cs_n;
endmodule
`default_nettype wire

// >>> rsl_loader.sv
// Added by the designer: strobed register access.
`default_nettype none
module rsl_loader #(
	parameter logic [7:0] PRE_MATCH_ON = 8'h01,
	parameter logic [7:0] AFC_MODE_BASE = 8'h00,
	parameter logic [7:0] SYNC_CFG_BASE = 8'h00,
	parameter int SPI_HALF = 2
) (
	input wire logic clock,
	input wire logic rst,
	input wire rsl_pkg::rsl_reg_addr_t reg_addr,
	input wire rsl_pkg::rsl_byte_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output rsl_pkg::rsl_byte_t reg_rdata,
	input wire logic dev_wake,
	output logic spi_sclk,
	output logic spi_mosi,
	output logic spi_cs_n
);
	import rsl_pkg::*;
	typedef struct packed {
		rsl_seq_t seq;
		logic [7:0] rdata;
		logic [1:0] setup;
		logic rate300;
		logic rate_fast;
		logic [7:0] pre_bytes;
		logic [7:0] base;
		logic [7:0] upper;
		logic [7:0] lower;
		logic auto_reload;
		logic wake_pend;
		logic busy;
		logic mcr_only;
		logic [3:0] step;
		logic req;
		logic [9:0] addr;
		logic [7:0] data;
		logic done;
		logic short;
	} rsl_top_st_t;
	localparam rsl_top_st_t ST_RST = '{seq: RSL_SEQ_IDLE, rdata: 8'h00, setup: RSL_SETUP_PRE, rate300: 1'b0,
		rate_fast: 1'b0, pre_bytes: RSL_PRE_RST, base: RSL_BASE_RST, upper: RSL_UPPER_REC, lower: RSL_LOWER_REC,
		auto_reload: 1'b0, wake_pend: 1'b0, busy: 1'b0, mcr_only: 1'b0, step: 4'h0, req: 1'b0,
		addr: 10'h000, data: 8'h00, done: 1'b0, short: 1'b0};
	rsl_top_st_t q;
	rsl_top_st_t d;
	logic [7:0] e_div;
	logic [7:0] e_mode;
	logic [7:0] e_gain;
	logic [7:0] e_pm;
	logic [7:0] e_sync;
	logic [6:0] e_min;
	logic start_full;
	logic start_mcr;
	logic [17:0] entry;
	rsl_wr_if wr();
	////////////////////////////////////////////////////////////////////////////////
	rsl_cfg_enc #(
		.PRE_MATCH_ON(PRE_MATCH_ON),
		.AFC_MODE_BASE(AFC_MODE_BASE),
		.SYNC_CFG_BASE(SYNC_CFG_BASE)
	) u_enc (
		.setup(q.setup),
		.rate300(q.rate300),
		.rate_fast(q.rate_fast),
		.div(e_div),
		.mode(e_mode),
		.gain(e_gain),
		.prematch(e_pm),
		.sync(e_sync),
		.min_bits(e_min)
	);
	rsl_spi_wr #(
		.HALF(SPI_HALF)
	) u_spi (
		.clock(clock),
		.rst(rst),
		.wr(wr.snk),
		.sclk(spi_sclk),
		.mosi(spi_mosi),
		.cs_n(spi_cs_n)
	);
	assign wr.req = q.req;
	assign wr.addr = q.addr;
	assign wr.data = q.data;
	assign reg_rdata = q.rdata;
	////////////////////////////////////////////////////////////////////////////////
	// one device write per step: mcr values, config, pointer, list
	function automatic logic [17:0] step_entry(input logic [3:0] s, input rsl_top_st_t c, input logic [7:0] dv,
		input logic [7:0] md, input logic [7:0] gn, input logic [7:0] pm, input logic [7:0] sc);
		logic [9:0] ret;
		ret = {RSL_RET_PAGE_HI, 8'(c.base + {4'h0, s} - {4'h0, RSL_STEP_LIST0})};
		case (s)
			4'h0: step_entry = {RSL_MCR_LOWER, c.lower};
			4'h1: step_entry = {RSL_MCR_UPPER, c.upper};
			4'h2: step_entry = {RSL_MCR_DIV, dv};
			4'h3: step_entry = {RSL_AFC_MODE, md};
			4'h4: step_entry = {RSL_AFC_GAIN, gn};
			4'h5: step_entry = {RSL_PRE_MATCH, pm};
			4'h6: step_entry = {RSL_PRE_LEN, c.pre_bytes};
			4'h7: step_entry = {RSL_SYNC_CFG, sc};
			4'h8: step_entry = {RSL_FIX_PTR, c.base};
			4'h9: step_entry = {ret, RSL_MCR_LOWER[7:0]};
			4'ha: step_entry = {ret, c.lower};
			4'hb: step_entry = {ret, RSL_MCR_UPPER[7:0]};
			4'hc: step_entry = {ret, c.upper};
			4'hd: step_entry = {ret, RSL_MCR_DIV[7:0]};
			4'he: step_entry = {ret, dv};
			default: step_entry = {ret, RSL_LIST_END};
		endcase
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.req = 1'b0;
		d.rdata = 8'h00;
		entry = step_entry(q.step, q, e_div, e_mode, e_gain, e_pm, e_sync);
		d.short = {q.pre_bytes, 3'h0} < {4'h0, e_min};
		start_full = reg_wr && (reg_addr == RSL_REG_CTRL) && reg_wdata[0];
		start_mcr = (reg_wr && (reg_addr == RSL_REG_CTRL) && reg_wdata[1]) || (q.wake_pend && q.auto_reload);
		if (reg_rd) begin
			case (reg_addr)
				RSL_REG_CTRL: d.rdata = {5'h00, q.auto_reload, 2'h0};
				RSL_REG_SETUP: d.rdata = {4'h0, q.rate_fast, q.rate300, q.setup};
				RSL_REG_PRE: d.rdata = q.pre_bytes;
				RSL_REG_BASE: d.rdata = q.base;
				RSL_REG_UPPER: d.rdata = q.upper;
				RSL_REG_LOWER: d.rdata = q.lower;
				RSL_REG_STATUS: d.rdata = {q.step, 1'b0, q.short, q.done, q.busy};
				default: d.rdata = 8'h00;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				RSL_REG_CTRL: d.auto_reload = reg_wdata[2];
				RSL_REG_STATUS: d.done = q.done && !reg_wdata[1];
				default: ;
			endcase
			// settings stay frozen while a sequence runs
			if (!q.busy) begin
				case (reg_addr)
					RSL_REG_SETUP: {d.rate_fast, d.rate300, d.setup} = reg_wdata[3:0];
					RSL_REG_PRE: d.pre_bytes = reg_wdata;
					RSL_REG_BASE: d.base = reg_wdata;
					RSL_REG_UPPER: d.upper = reg_wdata;
					RSL_REG_LOWER: d.lower = reg_wdata;
					default: ;
				endcase
			end
		end
		unique case (q.seq)
			RSL_SEQ_IDLE: begin
				if (start_full || start_mcr) begin
					d.busy = 1'b1;
					d.mcr_only = !start_full;
					d.step = 4'h0;
					d.wake_pend = 1'b0;
					d.seq = RSL_SEQ_ISSUE;
				end
			end
			RSL_SEQ_ISSUE: begin
				d.req = 1'b1;
				{d.addr, d.data} = entry;
				d.seq = RSL_SEQ_WAIT;
			end
			RSL_SEQ_WAIT: begin
				if (wr.done) begin
					if (q.step == (q.mcr_only ? RSL_STEP_MCR_LAST : RSL_STEP_LAST)) begin
						d.busy = 1'b0;
						d.done = 1'b1;
						d.seq = RSL_SEQ_IDLE;
					end else begin
						d.step = q.step + 4'h1;
						d.seq = RSL_SEQ_ISSUE;
					end
				end
			end
			default: d.seq = RSL_SEQ_IDLE;
		endcase
		// wake after sleep: mcr contents are gone
		if (dev_wake) begin
			d.wake_pend = 1'b1;
		end
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			q <= ST_RST;
		end else begin
			q <= d;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	localparam int WAIT_MAX = 300;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_ptr;
		q.req && q.step == 4'h8 |-> q.addr == RSL_FIX_PTR && q.data == q.base;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer write wrong");
	property p_list;
		q.req && q.step == RSL_STEP_LIST0 |-> q.addr == {RSL_RET_PAGE_HI, q.base} && q.data == 8'h5e;
	endproperty
	a_list: assert property (p_list) else $error("list start wrong");
	property p_term;
		q.req && q.step == RSL_STEP_LAST |-> q.data == 8'h00 ##[1:WAIT_MAX] (q.done && !q.busy);
	endproperty
	a_term: assert property (p_term) else $error("list end wrong");
	property p_upper;
		q.req && q.addr == RSL_MCR_UPPER |-> q.data == q.upper;
	endproperty
	a_upper: assert property (p_upper) else $error("upper level wrong");
	property p_lower;
		$rose(q.busy) |=> q.req && q.addr == RSL_MCR_LOWER && q.data == q.lower;
	endproperty
	a_lower: assert property (p_lower) else $error("lower level wrong");
	property p_div;
		q.req && q.addr == RSL_MCR_DIV |->
			q.data == ((q.rate300 && !q.setup[1]) ? 8'h0f : 8'h19);
	endproperty
	a_div: assert property (p_div) else $error("divider wrong");
	property p_gain;
		q.req && q.addr == RSL_AFC_GAIN |-> q.data == ((q.rate300 && q.setup == 2'h2) ? 8'h83 : 8'h73);
	endproperty
	a_gain: assert property (p_gain) else $error("loop gains wrong");
	property p_pre;
		q.req && q.addr == RSL_PRE_LEN |-> q.data == q.pre_bytes;
	endproperty
	a_pre: assert property (p_pre) else $error("preamble bytes wrong");
	property p_sync;
		q.req && q.addr == RSL_SYNC_CFG |-> q.data[0] == (q.rate_fast && q.setup[1]);
	endproperty
	a_sync: assert property (p_sync) else $error("sync tolerance wrong");
	property p_short;
		!q.busy && q.setup == 2'h1 && q.pre_bytes < 8'h05 && $stable(q.setup) && $stable(q.pre_bytes) |=> q.short;
	endproperty
	a_short: assert property (p_short) else $error("short preamble missed");
	property p_wake;
		dev_wake && q.auto_reload && q.seq == RSL_SEQ_IDLE |=> ##[1:2] q.busy;
	endproperty
	a_wake: assert property (p_wake) else $error("no reload after wake");
	////////////////////////////////////////////////////////////////////////////////
	// register port, sequencer and link framing
	property p_rd_zero;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data not cleared");
	property p_rd_base;
		reg_rd && reg_addr == RSL_REG_BASE |=> reg_rdata == $past(q.base);
	endproperty
	a_rd_base: assert property (p_rd_base) else $error("list base read wrong");
	property p_frozen;
		q.busy |=> $stable(q.base) && $stable(q.upper) && $stable(q.lower);
	endproperty
	a_frozen: assert property (p_frozen) else $error("settings moved while busy");
	property p_req_pulse;
		q.req |=> !q.req;
	endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("write request too long");
	property p_mcr_page;
		q.req && q.mcr_only |-> q.addr[9:8] == 2'h3;
	endproperty
	a_mcr_page: assert property (p_mcr_page) else $error("reload left modem page");
	property p_list_page;
		q.req && q.step >= RSL_STEP_LIST0 |-> q.addr[9:8] == RSL_RET_PAGE_HI;
	endproperty
	a_list_page: assert property (p_list_page) else $error("list left retained page");
	property p_list_upper;
		q.req && q.step == 4'hb |-> q.data == 8'h5f && q.addr == {RSL_RET_PAGE_HI, 8'(q.base + 8'h02)};
	endproperty
	a_list_upper: assert property (p_list_upper) else $error("list upper entry wrong");
	property p_list_div;
		q.req && q.step == 4'he |-> q.data == ((q.rate300 && !q.setup[1]) ? 8'h0f : 8'h19);
	endproperty
	a_list_div: assert property (p_list_div) else $error("list divider wrong");
	property p_done_end;
		q.seq == RSL_SEQ_WAIT && wr.done && !q.mcr_only && q.step == RSL_STEP_LAST |=> q.done && !q.busy;
	endproperty
	a_done_end: assert property (p_done_end) else $error("no done after list end");
	property p_done_clr;
		reg_wr && reg_addr == RSL_REG_STATUS && reg_wdata[1] && !wr.done |=> !q.done;
	endproperty
	a_done_clr: assert property (p_done_clr) else $error("done not cleared");
	property p_sclk_idle;
		spi_cs_n |-> !spi_sclk;
	endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("link clock runs outside frame");
	property p_idle_cs;
		q.seq == RSL_SEQ_IDLE |-> spi_cs_n;
	endproperty
	a_idle_cs: assert property (p_idle_cs) else $error("select low while idle");
	property p_frame_start;
		q.req |=> !spi_cs_n;
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("frame not started");
	property p_wake_pend;
		dev_wake |=> q.wake_pend;
	endproperty
	a_wake_pend: assert property (p_wake_pend) else $error("wake not recorded");
	c_full: cover property (q.req && q.step == RSL_STEP_LAST);
	c_mcr: cover property ($fell(q.busy) && q.mcr_only);
	c_wake: cover property (dev_wake && q.auto_reload);
	c_refused: cover property (q.busy && reg_wr && reg_addr == RSL_REG_UPPER);
endmodule
`default_nettype wire

// >>> rsl_dev_model.sv
`default_nettype none
module rsl_dev_model (
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	input wire logic spi_cs_n,
	input wire logic sleep
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:1023];
	logic [31:0] sh;
	logic [9:0] p;
	int n = 0;
	int frames = 0;
	int guard;
	logic [1:0] lock_mode;
	////////////////////////////////////////////////////////////////
	// frame capture: cmd, 6 spare, addr[9:0], data[7:0]
	always @(negedge spi_cs_n) n = 0;
	always @(posedge spi_sclk) if (!spi_cs_n) begin
		sh = {sh[30:0], spi_mosi};
		n++;
	end
	always @(posedge spi_cs_n) if (n == 32 && sh[31:24] == 8'h01) begin
		mem[sh[17:8]] = sh[7:0];
		frames++;
	end
	////////////////////////////////////////////////////////////////
	// sleep scrambles the modem page
	always @(posedge sleep) for (int a = 10'h300; a < 1024; a++) mem[a] = 8'ha5;
	// wake walks the retained fix-up list
	always @(negedge sleep) begin
		p = {2'h1, mem[10'h128]};
		guard = 0;
		while (mem[p] != 8'h00 && guard < 128) begin
			mem[{2'h3, mem[p]}] = mem[{2'h1, p[7:0] + 8'h01}];
			p = {2'h1, p[7:0] + 8'h02};
			guard++;
		end
	end
	////////////////////////////////////////////////////////////////
	// lock decode: 1 preamble lock, 2 sync lock, 3 loop off with gain on sync
	always_comb begin
		lock_mode = 2'h0;
		if (mem[10'h116][3:2] == 2'h3 && mem[10'h116][1:0] == 2'h3)
			lock_mode = (mem[10'h11b] != 8'h00) ? 2'h1 : 2'h2;
		else if (mem[10'h116][3:2] == 2'h3 && mem[10'h116][1:0] == 2'h1 && mem[10'h11b] == 8'h00)
			lock_mode = 2'h3;
	end
	wire logic sync_tol = mem[10'h120][0];
endmodule
`default_nettype wire

// >>> tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import rsl_pkg::*;
	logic clock = 0;
	logic rst = 1;
	rsl_reg_addr_t reg_addr = '0;
	rsl_byte_t reg_wdata = '0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	rsl_byte_t reg_rdata;
	logic dev_wake = 0;
	logic spi_sclk, spi_mosi, spi_cs_n;
	logic sleep = 0;
	int error_cnt = 0;
	int checks = 0;
	int cycles = 0;
	rsl_byte_t v;
	int f0;
	int sl [3] = '{2, 3, 1};
	rsl_byte_t rv [8] = '{8'h00, 8'h01, 8'h08, 8'h2b, 8'h78, 8'h46, 8'h00, 8'h00};
	rsl_loader i_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .dev_wake(dev_wake), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
		.spi_cs_n(spi_cs_n));
	rsl_dev_model i_dev (.spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_cs_n(spi_cs_n), .sleep(sleep));
	initial forever #2 clock = ~clock;
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask
	task automatic wr(input rsl_reg_addr_t a, input rsl_byte_t d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clock);
		reg_wr <= 0;
	endtask
	task automatic rd(input rsl_reg_addr_t a, output rsl_byte_t d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clock);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	task automatic wait_done();
		v = 8'h00;
		for (int i = 0; i < 3000 && v[1] !== 1'b1; i++) rd(RSL_REG_STATUS, v);
		chk("done", 8'h02, v & 8'h03);
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clock);
		rst <= 0;
		for (int a = 0; a < 8; a++) begin
			rd(a[3:0], v);
			chk("reset value", rv[a], v);
		end
		rd(4'hf, v);
		chk("unmapped", 8'h00, v);
		wr(RSL_REG_PRE, 8'h01);
		foreach (sl[k]) begin
			wr(RSL_REG_SETUP, 8'h0c | sl[k][7:0]);
			wr(RSL_REG_CTRL, 8'h01);
			wr(RSL_REG_UPPER, 8'h11);
			wait_done();
			chk("short flag", {5'h0, sl[k] != 3, 2'h0}, v & 8'h04);
			chk("busy write", 8'h78, i_dev.mem[10'h35f]);
			chk("lower", 8'h46, i_dev.mem[10'h35e]);
			chk("divider", sl[k] == 1 ? 8'h0f : 8'h19, i_dev.mem[10'h32f]);
			chk("gains", sl[k] == 2 ? 8'h83 : 8'h73, i_dev.mem[10'h117]);
			chk("lock mode", sl[k][7:0], {6'h0, i_dev.lock_mode});
			chk("tolerance", sl[k] != 1, {7'h0, i_dev.sync_tol});
			chk("preamble", 8'h01, i_dev.mem[10'h11d]);
			chk("pointer", 8'h2b, i_dev.mem[10'h128]);
			chk("list end", 8'h00, i_dev.mem[10'h131]);
			chk("list addr", 8'h5e, i_dev.mem[10'h12b]);
			wr(RSL_REG_STATUS, 8'h02);
			rd(RSL_REG_STATUS, v);
			chk("done clear", 8'h00, v & 8'h03);
		end
		// sleep then wake: device replays the fix-up list
		sleep <= 1;
		repeat (2) @(posedge clock);
		sleep <= 0;
		repeat (2) @(posedge clock);
		chk("fixup lower", 8'h46, i_dev.mem[10'h35e]);
		chk("fixup upper", 8'h78, i_dev.mem[10'h35f]);
		chk("fixup div", 8'h0f, i_dev.mem[10'h32f]);
		// automatic reload after wake carries a fresh threshold
		wr(RSL_REG_LOWER, 8'h40);
		wr(RSL_REG_CTRL, 8'h04);
		rd(RSL_REG_CTRL, v);
		chk("auto bit", 8'h04, v & 8'h04);
		f0 = i_dev.frames;
		@(posedge clock);
		dev_wake <= 1;
		@(posedge clock);
		dev_wake <= 0;
		wait_done();
		chk("reload frames", 8'h03, 8'(i_dev.frames - f0));
		chk("reload lower", 8'h40, i_dev.mem[10'h35e]);
		// manual reload, setup code 0 acting as preamble lock
		wr(RSL_REG_STATUS, 8'h02);
		wr(RSL_REG_SETUP, 8'h04);
		f0 = i_dev.frames;
		wr(RSL_REG_CTRL, 8'h06);
		wait_done();
		chk("manual frames", 8'h03, 8'(i_dev.frames - f0));
		chk("setup 0 divider", 8'h0f, i_dev.mem[10'h32f]);
		close_out();
	end
endmodule
`default_nettype wire
